//--- common/cdtc_pkg.sv
// cdtc_pkg: constants and carriers for the cordic timing and completion block
package cdtc_pkg;
   // register byte addresses (axi4-lite word aligned)
   localparam logic [7:0] XL_OFS = 8'h00;
   localparam logic [7:0] XH_OFS = 8'h04;
   localparam logic [7:0] YL_OFS = 8'h08;
   localparam logic [7:0] YH_OFS = 8'h0C;
   localparam logic [7:0] ZL_OFS = 8'h10;
   localparam logic [7:0] ZH_OFS = 8'h14;
   localparam logic [7:0] STAT_OFS = 8'h18;
   localparam logic [7:0] CON_OFS = 8'h1C;
   localparam logic [7:0] IMASK_OFS = 8'h20;
   // control register fields
   localparam int CON_START = 0;
   localparam int CON_DE = 1;
   localparam int CON_MC0 = 2;
   localparam int CON_ROTVEC = 4;
   localparam int CON_STMODE = 5;
   localparam int CON_XUSIGN = 6;
   localparam int CON_MPS0 = 7;
   localparam logic [7:0] CON_RESET = 8'h62;
   // status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_EOC = 1;
   localparam int ST_ERROR = 2;
   localparam int ST_INTEN = 3;
   localparam int ST_KEEPX = 4;
   localparam int ST_KEEPY = 5;
   localparam int ST_KEEPZ = 6;
   localparam int ST_DATA_MAP_SELECT = 7;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] STAT_WMASK = 8'hF8;
   // timing
   localparam int ITERATIONS = 16;
   localparam int CALC_BUDGET_CYC = 41;
   localparam int CYC_PER_ITER = 2;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      CIRCULAR,
      LINEAR,
      HYPERBOLIC
   } cdtc_func_t;
   typedef struct packed {
      logic signed [25:0] x;
      logic signed [25:0] y;
      logic signed [20:0] z;
   } cdtc_vec_t;
endpackage

//--- hw/cdtc_iter.sv
// cdtc_iter: one combinational cordic micro-rotation with barrel shifters
`timescale 1ns/1ps
module cdtc_iter (
   input wire cdtc_pkg::cdtc_vec_t vin,
   input wire logic [3:0] shift,
   input wire logic [19:0] angle,
   input wire logic rotate,
   input wire cdtc_pkg::cdtc_func_t func,
   output cdtc_pkg::cdtc_vec_t vout
);
   logic signed [25:0] xs;
   logic signed [25:0] ys;
   logic dir;
   logic signed [20:0] ang;
   always_comb begin
      // any shift distance in one pass, no serial shifting
      xs = vin.x >>> shift; // [RQ4]
      ys = vin.y >>> shift; // [RQ4]
      ang = $signed({1'b0, angle});
      dir = rotate ? ~vin.z[20] : vin.y[25];
      vout = vin;
      unique case (func)
         cdtc_pkg::CIRCULAR: begin
            vout.x = dir ? vin.x - ys : vin.x + ys;
         end
         cdtc_pkg::LINEAR: begin
            vout.x = vin.x;
         end
         cdtc_pkg::HYPERBOLIC: begin
            vout.x = dir ? vin.x + ys : vin.x - ys;
         end
      endcase
      vout.y = dir ? vin.y + xs : vin.y - xs;
      vout.z = dir ? vin.z - ang : vin.z + ang;
   end
endmodule

//--- hw/cdtc_top.sv
// cdtc_top: cordic coprocessor core with axi4-lite registers and completion irq
//
// Contract
// [RQ1] sixteen iterations per calculation, completion flag within 41 cycles of start
// [RQ2] error flag valid one cycle after completion; readers wait that cycle
// [RQ3] same budget for pre/post processed and hyperbolic modes incl. repeats
// [RQ4] operand shifts use barrel shifters, never bit-serial shifting
// [RQ5] end of calculation is the only interrupt source
// [RQ6] completion sets the flag; interrupt asserts when interrupt enable is 1 (the core also needs imask_q bit 1 set)
// [RQ7] flag holds until software clears, or low z read with map select 0
// [RQ8] error flag set on overflow of any result operand
// [RQ9] software checks error clear before trusting results
// [RQ10] keep bits start the next calculation from previous results
// [RQ11] software loads and reads six data registers outside the budget
// [RQ12] circular vectoring x and z deviations at most 1 for large inputs
// [RQ13] circular rotation x and y deviations at most 4 over full range
// [RQ14] hyperbolic rotation x deviation at most 8, y at most 7
// [RQ15] start bit cleared by hardware when the calculation begins
// [RQ16] control writes ignored while busy
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module cdtc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   typedef enum logic [1:0] {
      CDTC_IDLE,
      CDTC_SETUP,
      CDTC_ITER,
      CDTC_POST
   } cdtc_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // state
   cdtc_state_t state_q;
   logic [7:0] con_q;
   logic [7:0] stat_q;
   logic [7:0] imask_q;
   logic [15:0] xin_q, yin_q, zin_q;
   cdtc_pkg::cdtc_vec_t vec_q;
   cdtc_pkg::cdtc_vec_t vec_n;
   logic [15:0] xres_q, yres_q, zres_q;
   logic [4:0] iter_q;
   logic sub_q;
   logic rep_done_q;
   logic eoc_pulse_q;
   logic ovf_q;
   cdtc_pkg::cdtc_func_t func;
   logic rotate;
   logic [3:0] shift;
   logic [19:0] angle;
   logic busy;

   function automatic logic [19:0] atan_lut(input logic [3:0] i);
      logic [19:0] t [16];
      t = '{20'h2_0000, 20'h1_2E40, 20'h0_9FB4, 20'h0_5111, 20'h0_28B1, 20'h0_145D,
            20'h0_0A2F, 20'h0_0518, 20'h0_028C, 20'h0_0146, 20'h0_00A3, 20'h0_0051,
            20'h0_0029, 20'h0_0014, 20'h0_000A, 20'h0_0005};
      return t[i];
   endfunction

   function automatic logic [19:0] atanh_lut(input logic [3:0] i);
      logic [19:0] t [16];
      t = '{20'h0_0000, 20'h1_6618, 20'h0_A681, 20'h0_51EA, 20'h0_28CC, 20'h0_1461,
            20'h0_0A30, 20'h0_0518, 20'h0_028C, 20'h0_0146, 20'h0_00A3, 20'h0_0051,
            20'h0_0029, 20'h0_0014, 20'h0_000A, 20'h0_0005};
      return t[i];
   endfunction

   // true when a 26-bit kernel word does not fit the 16-bit result view
   function automatic logic ovf26(input logic signed [25:0] v);
      return (v[25:24] != {2{v[23]}});
   endfunction

   assign busy = stat_q[cdtc_pkg::ST_BUSY];
   assign rotate = con_q[cdtc_pkg::CON_ROTVEC];
   always_comb begin
      unique case (con_q[cdtc_pkg::CON_MC0 +: 2])
         2'b01: func = cdtc_pkg::LINEAR;
         2'b11: func = cdtc_pkg::HYPERBOLIC;
         default: func = cdtc_pkg::CIRCULAR;
      endcase
   end

   // hyperbolic starts at iteration 1 and repeats 4 and 13
   assign shift = iter_q[3:0];
   always_comb begin
      unique case (func)
         cdtc_pkg::CIRCULAR: angle = atan_lut(shift); // [RQ12] [RQ13]
         cdtc_pkg::LINEAR: angle = 20'h8_0000 >> shift;
         cdtc_pkg::HYPERBOLIC: angle = atanh_lut(shift); // [RQ14]
      endcase
   end

   cdtc_iter u_iter (
      .vin(vec_q),
      .shift(shift),
      .angle(angle),
      .rotate(rotate),
      .func(func),
      .vout(vec_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic rd_go;
   logic rd_zl;
   logic wr_con, wr_stat;
   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign wr_con = wr_go & wstrb_q[0] & (awaddr_q == cdtc_pkg::CON_OFS) & ~busy; // [RQ16]
   assign wr_stat = wr_go & wstrb_q[0] & (awaddr_q == cdtc_pkg::STAT_OFS);
   assign rd_zl = rd_go & (s_axi_araddr == cdtc_pkg::ZL_OFS) & ~stat_q[cdtc_pkg::ST_DATA_MAP_SELECT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cdtc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q > cdtc_pkg::IMASK_OFS || awaddr_q[1:0] != 2'b00) ?
                           cdtc_pkg::RESP_SLVERR : cdtc_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= cdtc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= cdtc_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            cdtc_pkg::XL_OFS: s_axi_rdata <= {24'h00_0000, xres_q[7:0]}; // [RQ11]
            cdtc_pkg::XH_OFS: s_axi_rdata <= {24'h00_0000, xres_q[15:8]};
            cdtc_pkg::YL_OFS: s_axi_rdata <= {24'h00_0000, yres_q[7:0]};
            cdtc_pkg::YH_OFS: s_axi_rdata <= {24'h00_0000, yres_q[15:8]};
            cdtc_pkg::ZL_OFS: s_axi_rdata <= {24'h00_0000, zres_q[7:0]};
            cdtc_pkg::ZH_OFS: s_axi_rdata <= {24'h00_0000, zres_q[15:8]};
            cdtc_pkg::STAT_OFS: s_axi_rdata <= {24'h00_0000, stat_q};
            cdtc_pkg::CON_OFS: s_axi_rdata <= {24'h00_0000, con_q};
            cdtc_pkg::IMASK_OFS: s_axi_rdata <= {24'h00_0000, imask_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cdtc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data registers: byte writes load initial operands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xin_q <= 16'h0000;
         yin_q <= 16'h0000;
         zin_q <= 16'h0000;
      end else if (wr_go && wstrb_q[0] && !busy) begin
         unique case (awaddr_q)
            cdtc_pkg::XL_OFS: xin_q[7:0] <= wdata_q[7:0];
            cdtc_pkg::XH_OFS: xin_q[15:8] <= wdata_q[7:0];
            cdtc_pkg::YL_OFS: yin_q[7:0] <= wdata_q[7:0];
            cdtc_pkg::YH_OFS: yin_q[15:8] <= wdata_q[7:0];
            cdtc_pkg::ZL_OFS: zin_q[7:0] <= wdata_q[7:0];
            cdtc_pkg::ZH_OFS: zin_q[15:8] <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         imask_q <= 8'h00;
      end else if (wr_go && wstrb_q[0] && awaddr_q == cdtc_pkg::IMASK_OFS) begin
         imask_q <= wdata_q[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register and calculation sequencer
   logic start;
   assign start = (state_q == CDTC_IDLE) & con_q[cdtc_pkg::CON_START];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         con_q <= cdtc_pkg::CON_RESET;
      end else if (start) begin
         con_q[cdtc_pkg::CON_START] <= 1'b0; // [RQ15]
      end else if (wr_con) begin
         con_q <= wdata_q[7:0]; // [RQ16]
      end
   end

   // two cycles per iteration: a barrel step and a count/repeat stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CDTC_IDLE;
         iter_q <= 5'd0;
         sub_q <= 1'b0;
         rep_done_q <= 1'b0;
         vec_q <= '0;
         eoc_pulse_q <= 1'b0;
      end else begin
         eoc_pulse_q <= 1'b0;
         unique case (state_q)
            CDTC_IDLE: begin
               if (start) begin
                  state_q <= CDTC_SETUP;
                  // kept operands reuse kernel words left by the previous run
                  if (!stat_q[cdtc_pkg::ST_KEEPX]) vec_q.x <= {{2{xin_q[15]}}, xin_q, 8'h00}; // [RQ10]
                  if (!stat_q[cdtc_pkg::ST_KEEPY]) vec_q.y <= {{2{yin_q[15]}}, yin_q, 8'h00}; // [RQ10]
                  if (!stat_q[cdtc_pkg::ST_KEEPZ]) vec_q.z <= {zin_q[15], zin_q, 4'h0}; // [RQ10]
               end
            end
            CDTC_SETUP: begin
               // one mode-setup cycle for every mode keeps timing uniform
               state_q <= CDTC_ITER; // [RQ3]
               iter_q <= (func == cdtc_pkg::HYPERBOLIC) ? 5'd1 : 5'd0;
               rep_done_q <= 1'b0;
               sub_q <= 1'b0;
            end
            CDTC_ITER: begin
               sub_q <= ~sub_q;
               if (!sub_q) begin
                  vec_q <= vec_n;
               end else if (func == cdtc_pkg::HYPERBOLIC && !rep_done_q &&
                            (iter_q == 5'd4 || iter_q == 5'd13)) begin
                  rep_done_q <= 1'b1; // [RQ3]
               end else begin
                  rep_done_q <= 1'b0;
                  iter_q <= iter_q + 5'd1;
                  if (iter_q == 5'(cdtc_pkg::ITERATIONS - 1)) begin // [RQ1]
                     state_q <= CDTC_POST;
                  end
               end
            end
            CDTC_POST: begin
               state_q <= CDTC_IDLE;
               eoc_pulse_q <= 1'b1; // [RQ1]
            end
         endcase
      end
   end

   // results settle before eoc; error follows one cycle after
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xres_q <= 16'h0000;
         yres_q <= 16'h0000;
         zres_q <= 16'h0000;
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= 1'b0;
         if (state_q == CDTC_POST) begin
            xres_q <= vec_q.x[23:8];
            yres_q <= vec_q.y[23:8];
            zres_q <= vec_q.z[19:4];
         end
         if (eoc_pulse_q) begin
            ovf_q <= ovf26(vec_q.x) | ovf26(vec_q.y) | (vec_q.z[20] != vec_q.z[19]); // [RQ8]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status register: busy, eoc, error, interrupt enable, keep, map select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= cdtc_pkg::STAT_RESET;
      end else begin
         if (wr_stat) begin
            stat_q[7:3] <= wdata_q[7:3];
            if (!wdata_q[cdtc_pkg::ST_EOC]) stat_q[cdtc_pkg::ST_EOC] <= 1'b0; // [RQ7]
            if (!wdata_q[cdtc_pkg::ST_ERROR]) stat_q[cdtc_pkg::ST_ERROR] <= 1'b0;
         end
         if (rd_zl) begin
            stat_q[cdtc_pkg::ST_EOC] <= 1'b0; // [RQ7]
         end
         if (start) begin
            stat_q[cdtc_pkg::ST_BUSY] <= 1'b1;
            stat_q[cdtc_pkg::ST_ERROR] <= 1'b0;
         end
         if (eoc_pulse_q) begin
            stat_q[cdtc_pkg::ST_BUSY] <= 1'b0;
            stat_q[cdtc_pkg::ST_EOC] <= 1'b1; // [RQ6]
         end
         // set wins over a same-cycle clear; valid one cycle after eoc
         if (ovf_q) begin
            stat_q[cdtc_pkg::ST_ERROR] <= 1'b1; // [RQ2] [RQ8]
         end
      end
   end

   // only eoc can request; mask bit gates it further
   assign irq = stat_q[cdtc_pkg::ST_EOC] & stat_q[cdtc_pkg::ST_INTEN] &
                imask_q[cdtc_pkg::ST_EOC]; // [RQ5] [RQ6]
endmodule

//--- test/cdtc_properties.sv
// cdtc_properties: port checks on bus answers and the completion interrupt
`timescale 1ns/1ps
module cdtc_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] since_q;
   logic [7:0] quiet_q;
   wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire rd_hs = s_axi_arvalid && s_axi_arready;
   ////////////////////////////////////////////////////////////////////////////////
   // cycles since a start write; saturating, so a late stray irq is caught too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_q <= 8'hFF;
      end else if (wr_hs && s_axi_awaddr == cdtc_pkg::CON_OFS && s_axi_wdata[0]) begin
         since_q <= 8'h00;
      end else if (since_q != 8'hFF) begin
         since_q <= since_q + 8'h01;
      end
   end
   // cycles since the last register access of either kind
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quiet_q <= 8'hFF;
      end else if (wr_hs || rd_hs) begin
         quiet_q <= 8'h00;
      end else if (quiet_q != 8'hFF) begin
         quiet_q <= quiet_q + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_b_answer;
      s_wr_take |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer missing");
   property p_r_answer;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer missing");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while answer open");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answer open");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h20)
         |=> s_axi_rresp == cdtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   // two bus cycles pass before the core sees the start bit, hence 41 plus 2
   property p_irq_budget;
      $rose(irq) |-> since_q >= 8'h11 && since_q <= 8'h2B;
   endproperty
   a_irq_budget: assert property (p_irq_budget) else $error("irq outside calc window");
   property p_irq_clear;
      $fell(irq) |-> quiet_q <= 8'h03;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq dropped with no access");
endmodule
bind cdtc_top cdtc_properties i_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .irq);

//--- test/cdtc_host.sv
// cdtc_host: register bus master standing in for the cpu core
`timescale 1ns/1ps
module cdtc_host (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // extra cycles before rready rises, to play a slow reader
   int lag = 0;
   initial begin
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // aw and w share one ready rule, so both are released at the same edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_bvalid);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (lag == 0);
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      repeat (lag) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // operands go in as six byte registers before the start write
   task automatic load(input logic [15:0] x, input logic [15:0] y);
      wr(cdtc_pkg::XL_OFS, 32'(x[7:0]));
      wr(cdtc_pkg::XH_OFS, 32'(x[15:8]));
      wr(cdtc_pkg::YL_OFS, 32'(y[7:0]));
      wr(cdtc_pkg::YH_OFS, 32'(y[15:8]));
      wr(cdtc_pkg::ZL_OFS, 32'h0000_0000);
      wr(cdtc_pkg::ZH_OFS, 32'h0000_0000);
   endtask
endmodule

//--- test/tb.sv
// tb: self-checking bench for the cordic completion block
`timescale 1ns/1ps
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb = 4'h1;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   cdtc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   cdtc_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rng(input string n, input int lo, input int hi, input logic [31:0] g);
      compares++;
      if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
         error_cnt++;
         $display("BAD %s exp %0d..%0d got %h", n, lo, hi, g);
      end
   endtask
   task automatic rdv(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      i_host.rd(a, d, r);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [31:0] v);
      logic [31:0] l, h;
      rdv(a, l);
      rdv(a + 8'h04, h);
      v = {16'h0000, h[7:0], l[7:0]};
   endtask
   // error flag trails completion by a cycle, so settle before any status read
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (irq !== 1'b1 && n < 80);
      repeat (2) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      chk("irq_reset", 32'h0000_0000, 32'(irq));
      rdv(cdtc_pkg::CON_OFS, d);
      chk("con_reset", 32'(cdtc_pkg::CON_RESET), d);
      rdv(cdtc_pkg::STAT_OFS, d);
      chk("stat_reset", 32'(cdtc_pkg::STAT_RESET), d);
      rdv(cdtc_pkg::IMASK_OFS, d);
      chk("imask_reset", 32'h0000_0000, d);
      i_host.lag = 2;
      i_host.rd(8'h24, d, r);
      i_host.lag = 0;
      chk("unmapped_resp", 32'(cdtc_pkg::RESP_SLVERR), 32'(r));
      i_host.wr(8'h24, 32'h0000_0000);
      chk("unmapped_bresp", 32'(cdtc_pkg::RESP_SLVERR), 32'(s_axi_bresp));
   endtask
   task automatic t_vector;
      logic [31:0] d, h;
      int n;
      i_host.wr(cdtc_pkg::IMASK_OFS, 32'h0000_0002);
      i_host.wr(cdtc_pkg::STAT_OFS, 32'h0000_0008);
      i_host.load(16'd1000, 16'h0000);
      i_host.wr(cdtc_pkg::CON_OFS, 32'h0000_0023);
      rdv(cdtc_pkg::CON_OFS, d);
      chk("start_clear", 32'h0000_0022, d);
      i_host.wr(cdtc_pkg::CON_OFS, 32'h0000_0000);
      rdv(cdtc_pkg::CON_OFS, d);
      chk("con_busy_write", 32'h0000_0022, d);
      rdv(cdtc_pkg::STAT_OFS, d);
      chk("busy", 32'h0000_0001, 32'(d[cdtc_pkg::ST_BUSY]));
      wait_irq(n);
      chk("irq_done", 32'h0000_0001, 32'(irq));
      rdv(cdtc_pkg::STAT_OFS, d);
      chk("stat_done", 32'h0000_000A, d);
      rd16(cdtc_pkg::XL_OFS, d);
      rng("x_vector", 1646, 1647, d);
      rdv(cdtc_pkg::ZH_OFS, h);
      rdv(cdtc_pkg::ZL_OFS, d);
      rng("z_vector", 0, 2, 32'(16'({h[7:0], d[7:0]} + 16'h0001)));
      repeat (2) @(posedge aclk);
      chk("irq_zl_clear", 32'h0000_0000, 32'(irq));
   endtask
   task automatic t_keep;
      logic [31:0] d;
      int n;
      i_host.wr(cdtc_pkg::STAT_OFS, 32'h0000_0078);
      i_host.wr(cdtc_pkg::CON_OFS, 32'h0000_0023);
      wait_irq(n);
      rd16(cdtc_pkg::XL_OFS, d);
      rng("x_keep", 2708, 2714, d);
      i_host.wr(cdtc_pkg::STAT_OFS, 32'h0000_0008);
      repeat (2) @(posedge aclk);
      chk("irq_sw_clear", 32'h0000_0000, 32'(irq));
   endtask
   task automatic t_overflow;
      logic [31:0] d;
      int n;
      i_host.wr(cdtc_pkg::IMASK_OFS, 32'h0000_0000);
      i_host.load(16'h7FFF, 16'h7FFF);
      i_host.wr(cdtc_pkg::CON_OFS, 32'h0000_0023);
      n = 0;
      do begin
         rdv(cdtc_pkg::STAT_OFS, d);
         n++;
      end while (d[cdtc_pkg::ST_BUSY] !== 1'b0 && n < 40);
      rdv(cdtc_pkg::STAT_OFS, d);
      chk("stat_overflow", 32'h0000_000E, d);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
      i_host.wr(cdtc_pkg::STAT_OFS, 32'h0000_0008);
      i_host.wr(cdtc_pkg::IMASK_OFS, 32'h0000_0002);
   endtask
   task automatic t_modes;
      logic [7:0] cons [4] = '{8'h33, 8'h3F, 8'h37, 8'h23};
      logic [31:0] d;
      int n;
      for (int i = 0; i < 4; i++) begin
         i_host.load(16'd1000, 16'h0000);
         i_host.wr(cdtc_pkg::CON_OFS, 32'(cons[i]));
         wait_irq(n);
         rng("calc_cycles", 16, 41, 32'(n));
         rdv(cdtc_pkg::STAT_OFS, d);
         chk("stat_mode", 32'h0000_000A, d);
         rd16(cdtc_pkg::XL_OFS, d);
         if (i == 0) begin
            rng("x_rotate", 1643, 1650, d);
         end
         if (i == 1) begin
            rng("x_hyp", 821, 836, d);
         end
         rdv(cdtc_pkg::ZL_OFS, d);
         repeat (2) @(posedge aclk);
         chk("irq_mode_clear", 32'h0000_0000, 32'(irq));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial begin
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_vector;
      t_keep;
      t_overflow;
      t_modes;
      report_and_stop;
   end
endmodule
